// ---- core/bsc_top.sv ----
// buck switcher clock and step control top
// Contract
// - multiplier code 000..111 selects factor 84,87,90,93,96,99,102,105 on the 32.768 kHz reference.
// - the default factor is 96, about 3.145728 MHz switching clock.
// - multiplier select is read/write and resets to 100 on main reset; force-on is read/write and clears on the reset pin.
// - the pll turns off when every switcher is off or in pfm and no other function needs the clock.
// - force-on set keeps the pll running; cleared leaves it under automatic control.
// - the clock is ready 88 cycles (704 ns) after demand from cold start and 76 cycles (608 ns) from pfm to pwm.
// - set-point changes ramp by 25 mV per time step, 4.0 us fixed for switchers 3 and 4, programmed for 1 and 2.
// - on activation the output steps up to its set point instead of jumping.
// - the current limiter is active unless the current-limit-disable bit is set.
// - switchers 2, 3 and 4 have a high-range bit; switcher 1 has only the low range.
// - each switcher has normal and standby set points; switchers 1 and 2 also take a pin-selected dvs set point.
// - each switcher mode is continuous pwm, pulse-skip pwm, pfm or adaptive.
// - switchers 1 and 2 use standby when both standby inputs are high, else dvs when the pin is high, else normal.
// - the dvs step-rate code 00..11 gives 2, 4, 8 or 16 us per step.
// - codes map from 0.600 V in 25 mV steps; switcher 1 stays in the 0.600 to 1.375 V range.
`timescale 1ns/10ps
`include "bsc_cfg.svh"

module bsc_top #(
   parameter int NUM_SW = 4,
   parameter int CODE_W = `BSC_CODE_W,
   parameter int TIMER_W = `BSC_TIMER_W
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic primary_reset_n_in,
   input wire logic osc_32k_in,
   input wire logic standby_in,
   input wire logic secondary_standby_input_in,
   input wire logic [1:0] voltage_scale_pin_in,
   input wire logic force_on_wr_in,
   input wire logic force_on_data_in,
   input wire logic mult_wr_in,
   input wire logic [2:0] mult_data_in,
   input wire logic current_limit_disable_in,
   input wire logic [NUM_SW-1:0] high_range_select_in,
   input wire logic [NUM_SW-1:0] sw_enable_in,
   input wire logic [2*NUM_SW-1:0] sw_mode_in,
   input wire logic [NUM_SW-1:0] light_load_in,
   input wire logic ext_clk_request_in,
   input wire logic [CODE_W*NUM_SW-1:0] normal_setpoint_in,
   input wire logic [CODE_W*NUM_SW-1:0] standby_setpoint_in,
   input wire logic [CODE_W*2-1:0] dvs_setpoint_in,
   input wire logic [3:0] dvs_step_rate_in,
   output logic pll_force_on_out,
   output logic [2:0] pll_multiplier_select_out,
   output logic [6:0] pll_factor_out,
   output logic pll_enable_out,
   output logic pll_ready_out,
   output logic pll_ref_out,
   output logic current_limit_active_out,
   output logic [NUM_SW-1:0] high_range_out,
   output logic [NUM_SW-1:0] pwm_active_out,
   output logic [NUM_SW-1:0] pulse_skip_out,
   output logic [CODE_W*NUM_SW-1:0] active_code_out,
   output logic [NUM_SW-1:0] at_target_out
);

   // --------------------------------------------------------------
   // timing counts
   // --------------------------------------------------------------
   localparam logic [7:0] COLD_CYC = 8'(`BSC_COLD_START_NS / `BSC_CLK_PERIOD_NS);
   localparam logic [7:0] WARM_CYC = 8'(`BSC_WARM_START_NS / `BSC_CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] STEP_2US_CYC = TIMER_W'(`BSC_STEP_2US_NS / `BSC_CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] STEP_4US_CYC = TIMER_W'(`BSC_STEP_4US_NS / `BSC_CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] STEP_8US_CYC = TIMER_W'(`BSC_STEP_8US_NS / `BSC_CLK_PERIOD_NS);
   localparam logic [TIMER_W-1:0] STEP_16US_CYC = TIMER_W'(`BSC_STEP_16US_NS / `BSC_CLK_PERIOD_NS);

   // --------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------
   localparam int PIN_W = 6;
   logic [PIN_W-1:0] pin_meta_r;
   logic [PIN_W-1:0] pin_sync_r;
   wire [PIN_W-1:0] pin_raw = {primary_reset_n_in, osc_32k_in, standby_in,
                               secondary_standby_input_in, voltage_scale_pin_in};

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pin_meta_r <= 6'h20;
         pin_sync_r <= 6'h20;
      end
      else if (ce_in)
      begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
      end
   end

   wire prim_rst_n_s = pin_sync_r[5];
   wire osc_s = pin_sync_r[4];
   wire standby_s = pin_sync_r[3];
   wire standby_sec_s = pin_sync_r[2];
   wire [1:0] dvs_pin_s = pin_sync_r[1:0];
   wire standby_both = standby_s & standby_sec_s;

   // --------------------------------------------------------------
   // pll control registers
   // --------------------------------------------------------------
   logic force_on_r;
   logic [2:0] mult_sel_r;

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         mult_sel_r <= `BSC_MULT_SEL_RESET;
      end
      else if (ce_in && mult_wr_in)
      begin
         mult_sel_r <= mult_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         force_on_r <= `BSC_FORCE_ON_RESET;
      end
      else if (ce_in)
      begin
         if (!prim_rst_n_s)
         begin
            force_on_r <= `BSC_FORCE_ON_RESET;
         end
         else if (force_on_wr_in)
         begin
            force_on_r <= force_on_data_in;
         end
      end
   end

   // --------------------------------------------------------------
   // per-switcher mode, set-point and step selection
   // --------------------------------------------------------------
   wire [NUM_SW-1:0] pfm_eff;
   wire [NUM_SW-1:0] pwm_eff;
   wire [NUM_SW-1:0] skip_eff;
   wire [NUM_SW-1:0] range_eff;
   wire [CODE_W-1:0] sel_point [NUM_SW];
   wire [TIMER_W-1:0] step_cyc [NUM_SW];

   genvar ch;
   generate
      for (ch = 0; ch < NUM_SW; ch++)
      begin : g_sw
         wire bsc_pkg::bsc_mode_t mode = bsc_pkg::bsc_mode_t'(sw_mode_in[2*ch+:2]);
         wire [CODE_W-1:0] normal_pt = normal_setpoint_in[CODE_W*ch+:CODE_W];
         wire [CODE_W-1:0] standby_pt = standby_setpoint_in[CODE_W*ch+:CODE_W];
         // adaptive falls to pfm only on light load
         assign pfm_eff[ch] = (mode == bsc_pkg::hysteretic_low_power_mode) ||
                              ((mode == bsc_pkg::adaptive_mode) && light_load_in[ch]);
         assign pwm_eff[ch] = sw_enable_in[ch] && !pfm_eff[ch];
         assign skip_eff[ch] = (mode == bsc_pkg::pulse_skip_pwm_mode);
         // switcher 1 has no high range
         assign range_eff[ch] = (ch == 0) ? 1'b0 : high_range_select_in[ch];
         if (ch < 2)
         begin : g_dvs
            wire [CODE_W-1:0] dvs_pt = dvs_setpoint_in[CODE_W*ch+:CODE_W];
            wire [1:0] rate = dvs_step_rate_in[2*ch+:2];
            // standby wins, then dvs pin, then normal
            assign sel_point[ch] = standby_both ? standby_pt :
                                   (dvs_pin_s[ch] ? dvs_pt : normal_pt);
            // programmed step time
            assign step_cyc[ch] = (rate == 2'h0) ? STEP_2US_CYC :
                                  (rate == 2'h1) ? STEP_4US_CYC :
                                  (rate == 2'h2) ? STEP_8US_CYC : STEP_16US_CYC;
         end
         else
         begin : g_fixed
            assign sel_point[ch] = standby_both ? standby_pt : normal_pt;
            assign step_cyc[ch] = STEP_4US_CYC;
         end

         bsc_stepper #(
            .CODE_W(CODE_W),
            .TIMER_W(TIMER_W)
         ) u_step (
            .clk_in(clk_in),
            .nrst_in(nrst_in),
            .ce_in(ce_in),
            .enable_in(sw_enable_in[ch]),
            .setpoint_in(sel_point[ch]),
            .step_cycles_in(step_cyc[ch]),
            .code_out(active_code_out[CODE_W*ch+:CODE_W]),
            .at_target_out(at_target_out[ch])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // pll demand and start-up
   // --------------------------------------------------------------
   wire pll_need = (|pwm_eff) || ext_clk_request_in;
   wire pll_want = force_on_r || pll_need;
   wire cold = ~(|sw_enable_in);
   wire [7:0] start_load = cold ? (COLD_CYC - 8'h01) : (WARM_CYC - 8'h01);

   bsc_pkg::bsc_pll_state_t pll_state_r;
   bsc_pkg::bsc_pll_state_t pll_state_nxt;
   logic [7:0] start_cnt_r;
   logic [7:0] start_cnt_nxt;

   always_comb
   begin
      pll_state_nxt = pll_state_r;
      start_cnt_nxt = start_cnt_r;
      unique case (pll_state_r)
         bsc_pkg::pll_off:
         begin
            if (pll_want)
            begin
               pll_state_nxt = bsc_pkg::pll_starting;
               start_cnt_nxt = start_load;
            end
         end
         bsc_pkg::pll_starting:
         begin
            if (!pll_want)
            begin
               pll_state_nxt = bsc_pkg::pll_off;
            end
            else if (start_cnt_r == 8'h00)
            begin
               pll_state_nxt = bsc_pkg::pll_running;
            end
            else
            begin
               start_cnt_nxt = start_cnt_r - 8'h01;
            end
         end
         bsc_pkg::pll_running:
         begin
            if (!pll_want)
            begin
               pll_state_nxt = bsc_pkg::pll_off;
            end
         end
         default:
         begin
            pll_state_nxt = bsc_pkg::pll_off;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pll_state_r <= bsc_pkg::pll_off;
         start_cnt_r <= 8'h00;
      end
      else if (ce_in)
      begin
         pll_state_r <= pll_state_nxt;
         start_cnt_r <= start_cnt_nxt;
      end
   end

   // --------------------------------------------------------------
   // registered outputs
   // --------------------------------------------------------------
   logic [6:0] factor_r;
   logic pll_en_r;
   logic pll_ready_r;
   logic pll_ref_r;
   logic ilim_r;
   logic [NUM_SW-1:0] range_r;
   logic [NUM_SW-1:0] pwm_r;
   logic [NUM_SW-1:0] skip_r;
   wire [6:0] factor_nxt = 7'(`BSC_FACTOR_BASE + `BSC_FACTOR_INCR * {4'h0, mult_sel_r});

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         factor_r <= 7'h60;
         pll_en_r <= 1'b0;
         pll_ready_r <= 1'b0;
         pll_ref_r <= 1'b0;
         ilim_r <= 1'b1;
         range_r <= '0;
         pwm_r <= '0;
         skip_r <= '0;
      end
      else if (ce_in)
      begin
         factor_r <= factor_nxt;
         pll_en_r <= (pll_state_nxt != bsc_pkg::pll_off);
         pll_ready_r <= (pll_state_nxt == bsc_pkg::pll_running);
         pll_ref_r <= osc_s && (pll_state_nxt != bsc_pkg::pll_off);
         ilim_r <= !current_limit_disable_in;
         range_r <= range_eff;
         pwm_r <= pwm_eff;
         skip_r <= skip_eff & pwm_eff;
      end
   end

   assign pll_force_on_out = force_on_r;
   assign pll_multiplier_select_out = mult_sel_r;
   assign pll_factor_out = factor_r;
   assign pll_enable_out = pll_en_r;
   assign pll_ready_out = pll_ready_r;
   assign pll_ref_out = pll_ref_r;
   assign current_limit_active_out = ilim_r;
   assign high_range_out = range_r;
   assign pwm_active_out = pwm_r;
   assign pulse_skip_out = skip_r;

endmodule

// ---- core/bsc_cfg.svh ----
// constants for the buck switcher clock and step control
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// --------------------------------------------------------------
// clock
// --------------------------------------------------------------
`define BSC_CLK_PERIOD_NS 8

// --------------------------------------------------------------
// pll multiplier
// --------------------------------------------------------------
`define BSC_MULT_SEL_RESET 3'h4
`define BSC_FACTOR_BASE 7'h54
`define BSC_FACTOR_INCR 7'h03
`define BSC_FORCE_ON_RESET 1'h0

// --------------------------------------------------------------
// pll start-up times in ns
// --------------------------------------------------------------
`define BSC_COLD_START_NS 700
`define BSC_WARM_START_NS 600

// --------------------------------------------------------------
// step times in ns
// --------------------------------------------------------------
`define BSC_STEP_2US_NS 2000
`define BSC_STEP_4US_NS 4000
`define BSC_STEP_8US_NS 8000
`define BSC_STEP_16US_NS 16000

// --------------------------------------------------------------
// set-point codes and step timer width
// --------------------------------------------------------------
`define BSC_CODE_W 5
`define BSC_SOFT_START_CODE 5'h00
`define BSC_TIMER_W 12

`endif

// ---- core/bsc_pkg.sv ----
// types for the buck switcher clock and step control
package bsc_pkg;

   // --------------------------------------------------------------
   // switcher operating modes
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      continuous_pwm_mode,
      pulse_skip_pwm_mode,
      hysteretic_low_power_mode,
      adaptive_mode
   } bsc_mode_t;

   // --------------------------------------------------------------
   // pll control states
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      pll_off,
      pll_starting,
      pll_running
   } bsc_pll_state_t;

endpackage

// ---- core/bsc_stepper.sv ----
// one-channel set-point stepping sequencer
`timescale 1ns/10ps
`include "bsc_cfg.svh"

module bsc_stepper #(
   parameter int CODE_W = `BSC_CODE_W,
   parameter int TIMER_W = `BSC_TIMER_W
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic enable_in,
   input wire logic [CODE_W-1:0] setpoint_in,
   input wire logic [TIMER_W-1:0] step_cycles_in,
   output logic [CODE_W-1:0] code_out,
   output logic at_target_out
);

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   logic active_r;
   logic active_nxt;
   logic [CODE_W-1:0] code_r;
   logic [CODE_W-1:0] code_nxt;
   logic [TIMER_W-1:0] timer_r;
   logic [TIMER_W-1:0] timer_nxt;
   logic at_target_r;

   wire step_due = (timer_r >= (step_cycles_in - TIMER_W'(1)));
   wire go_up = (code_r < setpoint_in);
   wire differs = (code_r != setpoint_in);

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb
   begin
      active_nxt = active_r;
      code_nxt = code_r;
      timer_nxt = timer_r;
      if (!enable_in)
      begin
         active_nxt = 1'b0;
         code_nxt = CODE_W'(`BSC_SOFT_START_CODE);
         timer_nxt = '0;
      end
      else if (!active_r)
      begin
         // soft start from the lowest code
         active_nxt = 1'b1;
         code_nxt = CODE_W'(`BSC_SOFT_START_CODE);
         timer_nxt = '0;
      end
      else if (differs)
      begin
         // one code per elapsed step, toward the live target
         if (step_due)
         begin
            timer_nxt = '0;
            code_nxt = go_up ? code_r + CODE_W'(1) : code_r - CODE_W'(1);
         end
         else
         begin
            timer_nxt = timer_r + TIMER_W'(1);
         end
      end
      else
      begin
         timer_nxt = '0;
      end
   end

   // --------------------------------------------------------------
   // registers
   // --------------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         active_r <= 1'b0;
         code_r <= CODE_W'(`BSC_SOFT_START_CODE);
         timer_r <= '0;
         at_target_r <= 1'b0;
      end
      else if (ce_in)
      begin
         active_r <= active_nxt;
         code_r <= code_nxt;
         timer_r <= timer_nxt;
         at_target_r <= active_nxt && (code_nxt == setpoint_in);
      end
   end

   assign code_out = code_r;
   assign at_target_out = at_target_r;

endmodule

// ---- testbench/bsc_top_chk.sv ----
// assertion checker for the buck switcher clock and step control
`timescale 1ns/10ps
module bsc_top_chk #(
   parameter int NUM_SW = 4,
   parameter int CODE_W = 5,
   parameter int TIMER_W = 12
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic ce_in,
   input wire logic primary_reset_n_in,
   input wire logic force_on_wr_in,
   input wire logic force_on_data_in,
   input wire logic mult_wr_in,
   input wire logic [2:0] mult_data_in,
   input wire logic [NUM_SW-1:0] sw_enable_in,
   input wire logic [2*NUM_SW-1:0] sw_mode_in,
   input wire logic [NUM_SW-1:0] light_load_in,
   input wire logic ext_clk_request_in,
   input wire logic osc_32k_in,
   input wire logic pll_force_on_out,
   input wire logic [2:0] pll_multiplier_select_out,
   input wire logic [6:0] pll_factor_out,
   input wire logic pll_enable_out,
   input wire logic pll_ready_out,
   input wire logic pll_ref_out,
   input wire logic [NUM_SW-1:0] pwm_active_out,
   input wire logic [NUM_SW-1:0] pulse_skip_out,
   input wire logic [CODE_W*NUM_SW-1:0] active_code_out
);
   // ------
   // helpers
   // ------
   logic [NUM_SW-1:0] pfm_w;
   logic [NUM_SW-1:0] skip_w;
   logic want_w;
   logic [CODE_W-1:0] code2_w;
   logic [7:0] on_cnt_r;
   logic cold_r;
   logic [CODE_W-1:0] prev_r;
   logic [10:0] gap_r;

   for (genvar i = 0; i < NUM_SW; i++)
   begin : g_mode
      assign pfm_w[i] = sw_mode_in[2*i+1 -: 2] == 2'h2 || (sw_mode_in[2*i+1 -: 2] == 2'h3 && light_load_in[i]);
      assign skip_w[i] = sw_mode_in[2*i+1 -: 2] == 2'h1;
   end
   assign want_w = pll_force_on_out | ext_clk_request_in | (|(sw_enable_in & ~pfm_w));
   assign code2_w = active_code_out[2*CODE_W +: CODE_W];

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         on_cnt_r <= 8'h00;
         cold_r <= 1'h1;
         prev_r <= '0;
         gap_r <= 11'h000;
      end
      else if (ce_in)
      begin
         on_cnt_r <= !want_w ? 8'h00 : (on_cnt_r == 8'hFF ? 8'hFF : on_cnt_r + 8'h01);
         if (want_w && on_cnt_r == 8'h00)
            cold_r <= ~|sw_enable_in;
         prev_r <= code2_w;
         gap_r <= (code2_w != prev_r) ? 11'h001 : (gap_r == 11'h7FF ? 11'h7FF : gap_r + 11'h001);
      end
   end

   // ------
   // properties
   // ------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in || !ce_in);

   sequence s_pin_low;
      !primary_reset_n_in [*3];
   endsequence
   sequence s_pin_high;
      primary_reset_n_in [*3];
   endsequence

   a_factor_map: assert property (1'b1 |=> pll_factor_out == 7'h54 + 7'h03 * $past(pll_multiplier_select_out))
      else $error("pll factor does not follow select");
   a_mult_write: assert property (mult_wr_in |=> pll_multiplier_select_out == $past(mult_data_in))
      else $error("multiplier select write lost");
   a_force_write: assert property (s_pin_high ##0 force_on_wr_in |=> pll_force_on_out == $past(force_on_data_in))
      else $error("force-on write lost");
   a_pin_clear: assert property (s_pin_low |=> !pll_force_on_out)
      else $error("force-on not cleared by reset pin");
   a_pll_enable: assert property (1'b1 |=> pll_enable_out == $past(want_w))
      else $error("pll enable does not follow demand");
   a_pll_ready: assert property (pll_ready_out == (on_cnt_r >= (cold_r ? 8'h58 : 8'h4C)))
      else $error("pll ready timing wrong");
   a_pwm_active: assert property (1'b1 |=> pwm_active_out == $past(sw_enable_in & ~pfm_w))
      else $error("pwm active wrong");
   a_skip_mode: assert property (1'b1 |=> pulse_skip_out == $past(sw_enable_in & ~pfm_w & skip_w))
      else $error("pulse skip wrong");
   a_ref_gate: assert property (pll_ref_out == ($past(osc_32k_in, 3) && pll_enable_out))
      else $error("pll reference not gated");
   a_step_size: assert property (code2_w != prev_r && prev_r != '0 && code2_w != '0 |->
      gap_r >= 11'h1F4 && (code2_w == prev_r + 1'b1 || code2_w == prev_r - 1'b1))
      else $error("step size or spacing wrong");
endmodule

bind bsc_top bsc_top_chk #(.NUM_SW(NUM_SW), .CODE_W(CODE_W), .TIMER_W(TIMER_W)) u_chk (
   .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .primary_reset_n_in(primary_reset_n_in),
   .force_on_wr_in(force_on_wr_in), .force_on_data_in(force_on_data_in), .mult_wr_in(mult_wr_in),
   .mult_data_in(mult_data_in), .sw_enable_in(sw_enable_in), .sw_mode_in(sw_mode_in),
   .light_load_in(light_load_in), .ext_clk_request_in(ext_clk_request_in), .pll_force_on_out(pll_force_on_out),
   .pll_multiplier_select_out(pll_multiplier_select_out), .pll_factor_out(pll_factor_out),
   .pll_enable_out(pll_enable_out), .pll_ready_out(pll_ready_out), .pwm_active_out(pwm_active_out),
   .pulse_skip_out(pulse_skip_out), .active_code_out(active_code_out), .osc_32k_in(osc_32k_in),
   .pll_ref_out(pll_ref_out)
);

// ---- testbench/buck_switcher_clock_and_step_control_test.sv ----
// self-checking bench for the buck switcher clock and step control
`timescale 1ns/10ps
module buck_switcher_clock_and_step_control_test;
   logic clk_in, nrst_in, ce_in, primary_reset_n_in, osc_32k_in, standby_in, secondary_standby_input_in;
   logic force_on_wr_in, force_on_data_in, mult_wr_in, current_limit_disable_in, ext_clk_request_in;
   logic [1:0] voltage_scale_pin_in;
   logic [2:0] mult_data_in, pll_multiplier_select_out;
   logic [3:0] high_range_select_in, sw_enable_in, light_load_in, dvs_step_rate_in;
   logic [7:0] sw_mode_in;
   logic [9:0] dvs_setpoint_in;
   logic [19:0] normal_setpoint_in, standby_setpoint_in, active_code_out;
   logic pll_force_on_out, pll_enable_out, pll_ready_out, pll_ref_out, current_limit_active_out;
   logic [6:0] pll_factor_out;
   logic [3:0] high_range_out, pwm_active_out, pulse_skip_out, at_target_out;
   int mismatches = 0;
   int n_checks = 0;
   int n;
   logic [4:0] p;
   logic [1:0] r;

   bsc_top DUT (
      .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .primary_reset_n_in(primary_reset_n_in),
      .osc_32k_in(osc_32k_in), .standby_in(standby_in), .secondary_standby_input_in(secondary_standby_input_in),
      .voltage_scale_pin_in(voltage_scale_pin_in), .force_on_wr_in(force_on_wr_in),
      .force_on_data_in(force_on_data_in), .mult_wr_in(mult_wr_in), .mult_data_in(mult_data_in),
      .current_limit_disable_in(current_limit_disable_in), .high_range_select_in(high_range_select_in),
      .sw_enable_in(sw_enable_in), .sw_mode_in(sw_mode_in), .light_load_in(light_load_in),
      .ext_clk_request_in(ext_clk_request_in), .normal_setpoint_in(normal_setpoint_in),
      .standby_setpoint_in(standby_setpoint_in), .dvs_setpoint_in(dvs_setpoint_in),
      .dvs_step_rate_in(dvs_step_rate_in), .pll_force_on_out(pll_force_on_out),
      .pll_multiplier_select_out(pll_multiplier_select_out), .pll_factor_out(pll_factor_out),
      .pll_enable_out(pll_enable_out), .pll_ready_out(pll_ready_out), .pll_ref_out(pll_ref_out),
      .current_limit_active_out(current_limit_active_out), .high_range_out(high_range_out),
      .pwm_active_out(pwm_active_out), .pulse_skip_out(pulse_skip_out), .active_code_out(active_code_out),
      .at_target_out(at_target_out)
   );

   // ------
   // helpers
   // ------
   function automatic logic [6:0] factor_of(input logic [2:0] s);
      return 7'h54 + 7'h03 * s;
   endfunction
   function automatic int step_of(input logic [1:0] rate);
      return 250 << rate;
   endfunction
   function automatic logic [4:0] pick(input logic [2:0] k, input logic [4:0] nrm, dvs, stb);
      return (k[2] & k[1]) ? stb : (k[0] ? dvs : nrm);
   endfunction
   function automatic logic [4:0] probe(input int w);
      return (w < 4) ? active_code_out[5*w +: 5] : {4'h0, pll_ready_out};
   endfunction

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      if (mismatches == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_for(input int w, input logic [4:0] v, output int cnt);
      cnt = 0;
      while (probe(w) !== v)
      begin
         tick(1);
         cnt++;
         if (cnt > 40000)
         begin
            mismatches++;
            final_report();
         end
      end
   endtask
   task automatic wr_mult(input logic [2:0] v);
      mult_wr_in = 1'b1;
      mult_data_in = v;
      tick(1);
      check(pll_multiplier_select_out, v);
   endtask

   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial
   begin
      osc_32k_in = 1'b0;
      forever
      begin
         repeat (15) @(posedge clk_in);
         #1 osc_32k_in = ~osc_32k_in;
      end
   end

   initial
   begin
      void'($urandom(62));
      nrst_in = 1'b0;
      ce_in = 1'b1;
      primary_reset_n_in = 1'b1;
      {standby_in, secondary_standby_input_in, voltage_scale_pin_in} = 4'h0;
      {force_on_wr_in, force_on_data_in, mult_wr_in, mult_data_in} = 6'h00;
      {current_limit_disable_in, high_range_select_in, sw_enable_in, light_load_in, ext_clk_request_in} = 14'h0000;
      {sw_mode_in, dvs_setpoint_in, dvs_step_rate_in} = 22'h000000;
      {normal_setpoint_in, standby_setpoint_in} = 40'h0000000000;
      tick(3);
      check(pll_multiplier_select_out, 3'h4);
      check(pll_factor_out, 7'h60);
      check(pll_force_on_out, 1'b0);
      check(current_limit_active_out, 1'b1);
      nrst_in = 1'b1;
      wr_mult(3'h0);
      for (int i = 1; i < 8; i++)
      begin
         wr_mult(i[2:0]);
         check(pll_factor_out, factor_of(3'(i - 1)));
      end
      mult_wr_in = 1'b0;
      tick(1);
      check(pll_factor_out, factor_of(3'h7));
      force_on_wr_in = 1'b1;
      force_on_data_in = 1'b1;
      tick(1);
      force_on_wr_in = 1'b0;
      check(pll_force_on_out, 1'b1);
      wait_for(4, 5'h01, n);
      check(n, 88);
      primary_reset_n_in = 1'b0;
      force_on_wr_in = 1'b1;
      tick(4);
      check(pll_force_on_out, 1'b0);
      check(pll_enable_out, 1'b0);
      force_on_wr_in = 1'b0;
      primary_reset_n_in = 1'b1;
      ext_clk_request_in = 1'b1;
      tick(1);
      check(pll_enable_out, 1'b1);
      ext_clk_request_in = 1'b0;
      tick(1);
      check(pll_enable_out, 1'b0);
      sw_enable_in[3] = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         sw_mode_in[7:6] = k[1:0];
         light_load_in[3] = k[2];
         tick(1);
         n = (k[1:0] == 2'h2 || (k[1:0] == 2'h3 && k[2])) ? 0 : 1;
         check(pwm_active_out[3], n[0]);
         check(pulse_skip_out[3], n[0] && k[1:0] == 2'h1);
         check(pll_enable_out, n[0]);
         check({at_target_out[3], active_code_out[19:15]}, 6'h20);
      end
      sw_mode_in[7:6] = 2'h0;
      wait_for(4, 5'h01, n);
      check(n, 76);
      sw_enable_in[3] = 1'b0;
      repeat (8)
      begin
         current_limit_disable_in = 1'($urandom);
         high_range_select_in = 4'($urandom);
         tick(1);
         check(current_limit_active_out, !current_limit_disable_in);
         check(high_range_out, {high_range_select_in[3:1], 1'b0});
      end
      dvs_step_rate_in = 4'($urandom);
      normal_setpoint_in[14:10] = 5'h02;
      sw_enable_in[2] = 1'b1;
      wait_for(2, 5'h02, n);
      check(n, 1001);
      check(at_target_out[2], 1'b1);
      sw_enable_in[2] = 1'b0;
      tick(1);
      check(active_code_out[14:10], 5'h00);
      r = dvs_step_rate_in[1:0];
      p = 5'($urandom_range(3, 1));
      normal_setpoint_in[4:0] = p;
      sw_enable_in[0] = 1'b1;
      wait_for(0, p, n);
      check(n, 1 + p * step_of(r));
      normal_setpoint_in[4:0] = p + 5'h02;
      wait_for(0, p + 5'h01, n);
      normal_setpoint_in[4:0] = 5'h00;
      wait_for(0, 5'h00, n);
      check(n, (p + 1) * step_of(r));
      check(at_target_out[0], 1'b1);
      normal_setpoint_in[9:5] = 5'h01;
      dvs_setpoint_in[9:5] = 5'h03;
      standby_setpoint_in[9:5] = 5'h05;
      sw_enable_in[1] = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         {standby_in, secondary_standby_input_in, voltage_scale_pin_in[1]} = k[2:0];
         tick(4);
         wait_for(1, pick(k[2:0], 5'h01, 5'h03, 5'h05), n);
         check(at_target_out[1], 1'b1);
      end
      final_report();
   end
endmodule
